// >>> design/msms_mem.v
`timescale 1ns/1ps
module msms_mem #(
  parameter AW = 8,
  parameter DW = 8
) (
  input  wire          clk,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);

  reg [DW-1:0] store [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end

endmodule // msms_mem

// >>> design/msms_regs.vh
`ifndef MSMS_REGS_VH
`define MSMS_REGS_VH

// Fixed device address, write form; bit 0 is the read/write select
`define MSMS_DEV_ADDR        8'ha0
`define MSMS_RW_BIT          0

// Word address counter, page layout and bit counter
`define MSMS_ADDR_BITS       8
`define MSMS_PAGE_BITS       7
`define MSMS_BYTE_BITS       8
`define MSMS_BITCNT_W        4
`define MSMS_LAST_BIT        4'h7
`define MSMS_FULL_BYTE       4'h8

// Clock and timing
`define MSMS_CLK_PERIOD_NS   20
`define MSMS_STRETCH_MAX_US  500
`define MSMS_STRETCH_MAX_CYC ((`MSMS_STRETCH_MAX_US * 1000) / `MSMS_CLK_PERIOD_NS)
`define MSMS_STRETCH_W       15
`define MSMS_FETCH_CYC       2

`endif

// >>> design/msms_slave.v
`timescale 1ns/1ps
`include "msms_regs.vh"

// Overview of operation
// [R1] Acts only as slave; host drives the clock and starts every transfer.
// [R2] Answers one hard-wired device address, write form A0h, not configurable.
// [R3] May hold SCL low before a read byte, never beyond 500 us.
// [R4] Host keeps the bus idle at least 20.8 us between transmissions.
// [R5] Samples SDA on SCL rise, changes own SDA on SCL fall.
// [R6] SDA is open drain: only pulled low or released, never driven high.
// [R7] Data changes only while SCL low; changes with SCL high mean START/STOP.
// [R8] SDA fall with SCL high is START; begin a new address byte.
// [R9] SDA rise with SCL high is STOP; ends the current transaction.
// [R10] All words are 8 bits, most significant bit first, both directions.
// [R11] Transmitter releases SDA for the ninth bit; receiver pulls low to ack.
// [R12] Acknowledge every matching address byte and every write data byte.
// [R13] Host acks each read byte except the last, then NACK and STOP.
// [R14] Host recovers a hung bus with up to nine clocks then START.
// [R15] Recovery resets only the interface state machine, nothing else.
// [R16] First word after START is the address; low bit high means read.
// [R17] On address match, drive zero on SDA during the acknowledge bit.
// [R18] Word address counter increments per word, wraps within 128-byte page.
// [R19] Repeated START after a write's word address abandons it, no increment.
// [R20] Keep sending read bytes while the host acknowledges each one.
// [R21] On address mismatch, leave SDA released and ignore the transaction.
module msms_slave #(
  parameter STRETCH_MAX_CYC = `MSMS_STRETCH_MAX_CYC,
  parameter AW              = `MSMS_ADDR_BITS
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          sclIn,
  output reg           sclOut,
  output reg           sclOeN,
  input  wire          sdaIn,
  output reg           sdaOut,
  output reg           sdaOeN,
  output reg           busy,
  output reg  [AW-1:0] wordAddr
);

  localparam [8:0] S_IDLE   = 9'h001;
  localparam [8:0] S_ADDR   = 9'h002;
  localparam [8:0] S_AACK   = 9'h004;
  localparam [8:0] S_WRX    = 9'h008;
  localparam [8:0] S_WACK   = 9'h010;
  localparam [8:0] S_STR    = 9'h020;
  localparam [8:0] S_TX     = 9'h040;
  localparam [8:0] S_RACK   = 9'h080;
  localparam [8:0] S_IGNORE = 9'h100;

  localparam [`MSMS_STRETCH_W-1:0] FETCH_CYC = `MSMS_FETCH_CYC;
  localparam [`MSMS_STRETCH_W-1:0] STR_LIMIT = STRETCH_MAX_CYC[`MSMS_STRETCH_W-1:0];
  localparam [7:0]                 DEV_ADDR  = `MSMS_DEV_ADDR;

  // Pin synchronisers; the first stage feeds only the second
  reg sclMeta;
  reg sclSync;
  reg sclPrev;
  reg sdaMeta;
  reg sdaSync;
  reg sdaPrev;

  reg [8:0]                  state;
  reg [`MSMS_BITCNT_W-1:0]   bitCnt;
  reg [7:0]                  rxShift;
  reg [7:0]                  txShift;
  reg                        readMode;
  reg                        firstWrite;
  reg [`MSMS_STRETCH_W-1:0]  stretchCnt;
  reg                        memWrEn;
  reg [7:0]                  memWrData;
  reg [AW-1:0]               memWrAddr;
  reg                        next_busy;

  wire [7:0] memRdData;
  wire       sclRise;
  wire       sclFall;
  wire       startSeen;
  wire       stopSeen;
  wire       addrMatch;
  wire       stretchDone;
  wire [AW-1:0] next_wordAddr;

  // Reset to the idle level, so no false edge follows reset
  always @(posedge clk) begin
    if (rst) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  assign sclRise   = sclSync & ~sclPrev;
  assign sclFall   = ~sclSync & sclPrev;
  // Both lines pass equal sync depth, so their relative order survives
  assign startSeen = sclSync & sclPrev & sdaPrev & ~sdaSync; // R8
  assign stopSeen  = sclSync & sclPrev & ~sdaPrev & sdaSync; // R9
  assign addrMatch = (rxShift[7:1] == DEV_ADDR[7:1]); // R2

  // Wrap keeps the top address bit, so the counter stays within its page
  assign next_wordAddr = {wordAddr[AW-1:`MSMS_PAGE_BITS],
                          wordAddr[`MSMS_PAGE_BITS-1:0] + 1'b1}; // R18

  // Fetch normally ends well before the ceiling; the ceiling is a backstop
  assign stretchDone = (stretchCnt >= FETCH_CYC) || (stretchCnt >= STR_LIMIT); // R3

  // Counts only while SCL is held; every other state parks it at zero
  always @(posedge clk) begin
    if (rst) begin
      stretchCnt <= {`MSMS_STRETCH_W{1'b0}};
    end else if (state == S_STR) begin
      stretchCnt <= stretchCnt + 1'b1; // R3
    end else begin
      stretchCnt <= {`MSMS_STRETCH_W{1'b0}};
    end
  end

  // A foreign transfer counts as free once its address mismatches; only its address byte looks like ours
  always @* begin
    next_busy = 1'b1;
    case (state)
      S_IDLE: begin
        next_busy = 1'b0;
      end
      S_IGNORE: begin
        next_busy = 1'b0; // R21
      end
      S_ADDR, S_AACK, S_WRX, S_WACK, S_STR, S_TX, S_RACK: begin
        next_busy = 1'b1;
      end
      default: begin
        next_busy = 1'b0;
      end
    endcase
  end

  // Contents are not reset; only host writes give them meaning

  msms_mem #(
    .AW (AW),
    .DW (8)
  ) u_mem (
    .clk    (clk),
    .wrEn   (memWrEn),
    .wrAddr (memWrAddr),
    .wrData (memWrData),
    .rdAddr (wordAddr),
    .rdData (memRdData)
  );

  always @(posedge clk) begin
    if (rst) begin
      state      <= S_IDLE;
      bitCnt     <= {`MSMS_BITCNT_W{1'b0}};
      rxShift    <= 8'h00;
      txShift    <= 8'h00;
      readMode   <= 1'b0;
      firstWrite <= 1'b0;
      memWrEn    <= 1'b0;
      memWrData  <= 8'h00;
      memWrAddr  <= {AW{1'b0}};
      wordAddr   <= {AW{1'b0}};
      sclOut     <= 1'b0;
      sclOeN     <= 1'b1;
      sdaOut     <= 1'b0; // R6
      sdaOeN     <= 1'b1;
      busy       <= 1'b0;
    end else begin
      memWrEn <= 1'b0;
      sclOut  <= 1'b0;
      sdaOut  <= 1'b0; // R6
      busy    <= next_busy;
      if (startSeen) begin
        // Also the hung-bus recovery: only this machine restarts, memory and
        // word counter are kept; a pending write is simply dropped
        state   <= S_ADDR; // R8 R15 R19 R14
        bitCnt  <= {`MSMS_BITCNT_W{1'b0}};
        sdaOeN  <= 1'b1;
        sclOeN  <= 1'b1;
      end else if (stopSeen) begin
        state   <= S_IDLE; // R9 R13
        sdaOeN  <= 1'b1;
        sclOeN  <= 1'b1;
      end else begin
        case (state)
          S_IDLE: begin
            sdaOeN <= 1'b1; // R1
            sclOeN <= 1'b1;
          end
          S_ADDR: begin
            if (sclRise) begin
              rxShift <= {rxShift[6:0], sdaSync}; // R5 R10 R16
              bitCnt  <= bitCnt + 1'b1;
            end else if (sclFall && bitCnt == `MSMS_FULL_BYTE) begin
              if (addrMatch) begin
                readMode <= rxShift[`MSMS_RW_BIT]; // R16
                sdaOeN   <= 1'b0; // R17 R12 R11
                state    <= S_AACK;
              end else begin
                state    <= S_IGNORE; // R21
              end
            end
          end
          S_AACK: begin
            if (sclFall) begin
              sdaOeN <= 1'b1; // R11
              bitCnt <= {`MSMS_BITCNT_W{1'b0}};
              if (readMode) begin
                sclOeN     <= 1'b0; // R3
                state      <= S_STR;
              end else begin
                firstWrite <= 1'b1;
                state      <= S_WRX;
              end
            end
          end
          S_WRX: begin
            if (sclRise) begin
              rxShift <= {rxShift[6:0], sdaSync}; // R5 R10
              bitCnt  <= bitCnt + 1'b1;
            end else if (sclFall && bitCnt == `MSMS_FULL_BYTE) begin
              sdaOeN <= 1'b0; // R12 R11
              state  <= S_WACK;
              if (firstWrite) begin
                wordAddr   <= rxShift; // R19
                firstWrite <= 1'b0;
              end else begin
                memWrEn   <= 1'b1;
                memWrAddr <= wordAddr;
                memWrData <= rxShift;
                wordAddr  <= next_wordAddr; // R18
              end
            end
          end
          S_WACK: begin
            if (sclFall) begin
              sdaOeN <= 1'b1; // R11
              bitCnt <= {`MSMS_BITCNT_W{1'b0}};
              state  <= S_WRX;
            end
          end
          S_STR: begin
            // Read port follows the word counter; hold SCL until data settles
            if (stretchDone) begin
              txShift  <= memRdData;
              sdaOeN   <= memRdData[7]; // R6 R10
              sclOeN   <= 1'b1; // R3
              wordAddr <= next_wordAddr; // R18
              bitCnt   <= {`MSMS_BITCNT_W{1'b0}};
              state    <= S_TX;
            end
          end
          S_TX: begin
            if (sclFall) begin
              if (bitCnt == `MSMS_LAST_BIT) begin
                sdaOeN <= 1'b1; // R11
                state  <= S_RACK;
              end else begin
                txShift <= {txShift[6:0], 1'b0};
                sdaOeN  <= txShift[6]; // R5 R7 R10
                bitCnt  <= bitCnt + 1'b1;
              end
            end
          end
          S_RACK: begin
            if (sclRise && sdaSync) begin
              state <= S_IGNORE; // R13 R20
            end else if (sclFall) begin
              sclOeN     <= 1'b0; // R20 R3
              state      <= S_STR;
            end
          end
          S_IGNORE: begin
            sdaOeN <= 1'b1; // R21
            sclOeN <= 1'b1;
          end
          default: begin
            state  <= S_IDLE;
            sdaOeN <= 1'b1;
            sclOeN <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // msms_slave

// >>> dv/module_mgmt_serial_slave_bench.sv
`timescale 1ns/1ps
module module_mgmt_serial_slave_bench;
  reg        clk;
  reg        rst;
  wire       sclRel, sdaRel, sclOeN, sdaOeN, sclOut, sdaOut, busy;
  wire [7:0] wordAddr;
  wire       scl = sclOeN & sclRel;
  wire       sda = sdaOeN & sdaRel;
  integer    nErrors, samplesChecked;
  reg  [7:0] q;
  reg        a;
`define CHK(x, y) chk(x, y)
  msms_slave #(.STRETCH_MAX_CYC(8)) i_dut (.clk(clk), .rst(rst), .sclIn(scl),
    .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .busy(busy), .wordAddr(wordAddr));
  msms_host_model i_host (.clk(clk), .scl(scl), .sda(sda), .sclRel(sclRel), .sdaRel(sdaRel));
  task chk(input [7:0] g, input [7:0] e);
    begin
      samplesChecked = samplesChecked + 1;
      if (g !== e) begin
        nErrors = nErrors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task finish_test;
    begin
      if (nErrors == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task t_write;
    begin
      i_host.start;
      i_host.xfer(8'ha0, 1'b1, q, a);
      `CHK(a, 1'b0);
      i_host.xfer(8'h7f, 1'b1, q, a);
      `CHK(a, 1'b0);
      `CHK(wordAddr, 8'h7f);
      i_host.xfer(8'h55, 1'b1, q, a);
      i_host.xfer(8'haa, 1'b1, q, a);
      `CHK(a, 1'b0);
      i_host.stop;
      `CHK(wordAddr, 8'h01);
    end
  endtask
  task t_read;
    begin
      i_host.start;
      i_host.xfer(8'ha0, 1'b1, q, a);
      i_host.xfer(8'h7f, 1'b1, q, a);
      i_host.start;
      i_host.xfer(8'ha1, 1'b1, q, a);
      `CHK(a, 1'b0);
      i_host.xfer(8'hff, 1'b0, q, a);
      `CHK(q, 8'h55);
      i_host.xfer(8'hff, 1'b1, q, a);
      `CHK(q, 8'haa);
      i_host.stop;
      `CHK(wordAddr, 8'h01);
    end
  endtask
  task t_other;
    begin
      i_host.start;
      i_host.xfer(8'h20, 1'b1, q, a);
      `CHK(a, 1'b1);
      i_host.xfer(8'h00, 1'b1, q, a);
      `CHK(a, 1'b1);
      `CHK(busy, 1'b0);
      i_host.stop;
    end
  endtask
  task t_recover;
    begin
      i_host.start;
      i_host.xfer(8'ha0, 1'b1, q, a);
      i_host.bitIo(1'b0, a);
      i_host.bitIo(1'b1, a);
      i_host.recover;
      i_host.stop;
      `CHK(wordAddr, 8'h01);
      `CHK(busy, 1'b0);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    nErrors = 0;
    samplesChecked = 0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_write;
    t_read;
    t_other;
    t_recover;
    finish_test;
  end
  initial begin
    #400000;
    nErrors = nErrors + 1;
    finish_test;
  end
endmodule // module_mgmt_serial_slave_bench
bind msms_slave msms_slave_props #(.STRETCH_MAX_CYC(STRETCH_MAX_CYC), .AW(AW)) i_props (
  .clk(clk), .rst(rst), .sclIn(sclIn), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOeN(sdaOeN), .busy(busy), .wordAddr(wordAddr));

// >>> dv/msms_host_model.sv
`timescale 1ns/1ps
module msms_host_model (
  input  wire clk,
  input  wire scl,
  input  wire sda,
  output reg  sclRel,
  output reg  sdaRel
);
  localparam BUF_CYC = 1040;
  initial begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
  end
  // One bit; low phase waits out any stretch, bounded
  task bitIo(input b, output r);
    integer k;
    begin
      @(posedge clk);
      sdaRel <= b;
      repeat (3) @(posedge clk);
      sclRel <= 1'b1;
      k = 0;
      do begin
        @(negedge clk);
        k = k + 1;
      end while (!scl && k < 50);
      repeat (3) @(posedge clk);
      @(negedge clk);
      r = sda;
      @(posedge clk);
      sclRel <= 1'b0;
    end
  endtask
  task xfer(input [7:0] d, input a, output [7:0] q, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitIo(d[i], r);
        q[i] = r;
      end
      bitIo(a, ack);
    end
  endtask
  task start;
    begin
      @(posedge clk);
      sdaRel <= 1'b1;
      repeat (3) @(posedge clk);
      sclRel <= 1'b1;
      repeat (4) @(posedge clk);
      sdaRel <= 1'b0;
      repeat (4) @(posedge clk);
      sclRel <= 1'b0;
    end
  endtask
  task stop;
    begin
      @(posedge clk);
      sdaRel <= 1'b0;
      repeat (3) @(posedge clk);
      sclRel <= 1'b1;
      repeat (4) @(posedge clk);
      sdaRel <= 1'b1;
      repeat (BUF_CYC) @(posedge clk);
    end
  endtask
  task recover;
    integer n;
    reg r;
    begin
      r = 1'b0;
      for (n = 0; n < 9 && !r; n = n + 1) bitIo(1'b1, r);
      start;
    end
  endtask
endmodule // msms_host_model

// >>> dv/msms_slave_props.sv
`timescale 1ns/1ps
module msms_slave_props #(
  parameter STRETCH_MAX_CYC = 8,
  parameter AW              = 8
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          sclIn,
  input wire logic          sclOut,
  input wire logic          sclOeN,
  input wire logic          sdaIn,
  input wire logic          sdaOut,
  input wire logic          sdaOeN,
  input wire logic          busy,
  input wire logic [AW-1:0] wordAddr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_scl_no_high: assert property (sclOut == 1'b0)
    else $error("scl driven high");
  chk_sda_no_high: assert property (sdaOut == 1'b0)
    else $error("sda driven high");
  chk_stretch_len: assert property ($fell(sclOeN) |-> ##[1:8] sclOeN)
    else $error("stretch too long");
  chk_stretch_low: assert property ($fell(sclOeN) |-> !$past(sclIn))
    else $error("stretch began with scl high");
  chk_sda_scl_low: assert property ($changed(sdaOeN) |-> !$past(sclIn))
    else $error("sda changed with scl high");
  chk_addr_busy: assert property ($changed(wordAddr) |-> busy)
    else $error("counter moved while idle");
  chk_idle_free: assert property (!busy [*2] |-> sdaOeN && sclOeN)
    else $error("pin held while idle");
  chk_stop_idle: assert property ($rose(sdaIn) && sclIn && $past(sclIn) |-> ##[2:6] !busy)
    else $error("stop not seen");
  chk_start_busy: assert property ($fell(sdaIn) && sclIn && $past(sclIn) |-> ##[2:6] busy)
    else $error("start not seen");
  cov_stretch: cover property ($fell(sclOeN));
  cov_ack: cover property ($fell(sdaOeN));
  cov_addr: cover property ($changed(wordAddr));
endmodule // msms_slave_props
